// ===== cgc_config_ctrl.sv
/*
 * configuration loader, save/restore sequencer and output gating
 * assumes: link byte framing on linkClk, memory engine answers otpDone
 */
`timescale 1ns/10ps
`include "cgc_regs.svh"

module cgc_config_ctrl #(
    parameter int unsigned POR_CYCLES    = `CGC_POR_MS * 1000 * `CGC_CLK_MHZ,
    parameter int unsigned SETTLE_CYCLES = `CGC_SETTLE_US * `CGC_CLK_MHZ
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        strapLatchPin,
    input  wire logic                        configChoiceLo,
    input  wire logic                        configChoiceHi,
    input  wire logic                        powerDownOrGatePin,
    input  wire logic                        i2cDefaultPickBit,
    input  wire logic                        slaveAddrSelBit,
    input  wire logic                        otpSaveTrigger,
    input  wire logic                        otpRestoreTrigger,
    input  wire logic                        otpDone,
    input  wire logic                        pinPolarityBit,
    input  wire logic                        pinFunctionBit,
    input  wire logic [`CGC_NUM_OUT-1:0]     outputActiveBit,
    input  wire logic [`CGC_NUM_OUT-1:0]     outputEnableBit,
    input  wire logic [5:0]                  crystalTuneCode,
    input  wire logic                        spreadEnable,
    input  wire logic                        spreadDownMode,
    input  wire logic [3:0]                  spreadCode,
    input  wire logic                        linkClk,
    input  wire logic                        linkAddrValid,
    input  wire logic [7:0]                  linkAddrByte,
    input  wire logic                        linkDataValid,
    input  wire logic [7:0]                  linkDataByte,
    input  wire logic                        linkStop,
    output logic                             linkAck,
    output logic                             configLoadReq,
    output logic [1:0]                       configLoadSel,
    output logic                             loadI2cDefaults,
    output logic                             i2cAccessEn,
    output logic                             deviceReady,
    output logic                             otpSaveStart,
    output logic                             otpRestoreStart,
    output logic                             globalShutdown,
    output logic [2*`CGC_NUM_OUT-1:0]        outputMode,
    output logic [6:0]                       crystalCapHalfPf,
    output logic                             spreadActive,
    output logic [4:0]                       spreadDevQuarterPct
);

    // ************************************
    // declarations
    // ************************************
    cgc_pkg::cgc_state_t state;
    logic [17:0]         cnt;
    logic [17:0]         porCnt;
    logic                porDone;
    logic [3:0]          pinMeta;
    logic [3:0]          pinSync;
    logic                reqMeta;
    logic                reqSync;
    logic                reqPrev;
    logic                reqTgl;
    logic                ackTgl;
    logic                cmdIsSave;
    logic                hwSelMode;
    logic [1:0]          lastSel;
    logic                linkPend;
    logic                savePend;
    logic                restPend;
    logic                saveTrgPrev;
    logic                restTrgPrev;
    logic                opFromLink;
    logic                selUsesPins;
    logic [1:0]          pinSel;
    logic                rstMeta;
    logic                linkRst;
    logic [3:0]          lnkMeta;
    logic [3:0]          lnkSync;
    logic                linkBusy;
    logic                addrMatch;
    logic                addressed;
    logic                writeDir;
    logic [1:0]          byteCnt;
    logic [7:0]          cmdCode;
    logic [7:0]          ownAddr;

    // ************************************
    // output gating decode
    // ************************************
    function automatic cgc_pkg::cgc_mode_t gate_mode(
        input logic func,
        input logic pol,
        input logic act,
        input logic en,
        input logic pin
    );
        if (func && pin)
            gate_mode = cgc_pkg::MODE_SHUT;
        else if (!act)
            gate_mode = cgc_pkg::MODE_TRI;
        else if (!en)
            gate_mode = cgc_pkg::MODE_ACTIVE;
        else if (func)
            gate_mode = pol ? cgc_pkg::MODE_HILO : cgc_pkg::MODE_ACTIVE;
        else
            gate_mode = (pin ^ pol) ? cgc_pkg::MODE_HILO : cgc_pkg::MODE_ACTIVE;
    endfunction : gate_mode

    // ************************************
    // synchronisers, system side
    // ************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pinMeta <= 4'h0;
            pinSync <= 4'h0;
            reqMeta <= 1'b0;
            reqSync <= 1'b0;
            reqPrev <= 1'b0;
        end
        else
        begin
            pinMeta <= {strapLatchPin, configChoiceHi, configChoiceLo, powerDownOrGatePin};
            pinSync <= pinMeta;
            reqMeta <= reqTgl;
            reqSync <= reqMeta;
            reqPrev <= reqSync;
        end
    end

    assign pinSel      = pinSync[2:1];
    assign selUsesPins = hwSelMode && !i2cDefaultPickBit;

    // ************************************
    // power-up window
    // ************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            porCnt  <= 18'h00000;
            porDone <= 1'b0;
        end
        else if (!porDone)
        begin
            porCnt  <= porCnt + 18'h00001;
            porDone <= (porCnt == 18'(POR_CYCLES - 1));
        end
    end

    // ************************************
    // pending operations
    // ************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            linkPend    <= 1'b0;
            savePend    <= 1'b0;
            restPend    <= 1'b0;
            saveTrgPrev <= 1'b0;
            restTrgPrev <= 1'b0;
        end
        else
        begin
            saveTrgPrev <= otpSaveTrigger;
            restTrgPrev <= otpRestoreTrigger;
            if (reqSync != reqPrev)
                linkPend <= 1'b1;
            else if (state == cgc_pkg::ST_RUN)
                linkPend <= 1'b0;
            if (otpSaveTrigger && !saveTrgPrev)
                savePend <= 1'b1;
            else if (state == cgc_pkg::ST_RUN && !linkPend)
                savePend <= 1'b0;
            if (otpRestoreTrigger && !restTrgPrev)
                restPend <= 1'b1;
            else if (state == cgc_pkg::ST_RUN && !linkPend && !savePend)
                restPend <= 1'b0;
        end
    end

    // ************************************
    // sequencer
    // ************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state           <= cgc_pkg::ST_STRAP;
            cnt             <= 18'h00000;
            hwSelMode       <= 1'b0;
            lastSel         <= 2'h0;
            configLoadReq   <= 1'b0;
            configLoadSel   <= 2'h0;
            loadI2cDefaults <= 1'b0;
            otpSaveStart    <= 1'b0;
            otpRestoreStart <= 1'b0;
            opFromLink      <= 1'b0;
            ackTgl          <= 1'b0;
        end
        else
        begin
            configLoadReq   <= 1'b0;
            otpSaveStart    <= 1'b0;
            otpRestoreStart <= 1'b0;
            case (state)
                cgc_pkg::ST_STRAP:
                begin
                    cnt <= cnt + 18'h00001;
                    if (cnt == `CGC_SYNC_WAIT)
                    begin
                        hwSelMode       <= pinSync[3];
                        otpRestoreStart <= 1'b1;
                        state           <= cgc_pkg::ST_RESTORE;
                    end
                end
                cgc_pkg::ST_RESTORE:
                    if (otpDone)
                        state <= cgc_pkg::ST_LOAD;
                cgc_pkg::ST_LOAD:
                begin
                    configLoadReq   <= 1'b1;
                    configLoadSel   <= selUsesPins ? pinSel : 2'h0;
                    loadI2cDefaults <= !hwSelMode && i2cDefaultPickBit;
                    lastSel         <= pinSel;
                    cnt             <= 18'h00000;
                    state           <= cgc_pkg::ST_SETTLE;
                end
                cgc_pkg::ST_SETTLE:
                begin
                    cnt <= cnt + 18'h00001;
                    if (cnt == 18'(SETTLE_CYCLES - 1))
                        state <= cgc_pkg::ST_RUN;
                end
                cgc_pkg::ST_RUN:
                    if (linkPend || savePend || restPend)
                    begin
                        opFromLink      <= linkPend;
                        otpSaveStart    <= linkPend ? cmdIsSave : savePend;
                        otpRestoreStart <= linkPend ? !cmdIsSave : !savePend;
                        state           <= cgc_pkg::ST_OTP;
                    end
                    else if (selUsesPins && porDone && pinSel != lastSel)
                        state <= cgc_pkg::ST_LOAD;
                cgc_pkg::ST_OTP:
                    if (otpDone)
                    begin
                        if (opFromLink)
                            ackTgl <= !ackTgl;
                        state <= cgc_pkg::ST_RUN;
                    end
                default:
                    state <= cgc_pkg::ST_STRAP;
            endcase
        end
    end

    // ************************************
    // status and analog settings
    // ************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            deviceReady         <= 1'b0;
            i2cAccessEn         <= 1'b0;
            crystalCapHalfPf    <= `CGC_CAP_BASE;
            spreadActive        <= 1'b0;
            spreadDevQuarterPct <= 5'h00;
        end
        else
        begin
            deviceReady      <= (state == cgc_pkg::ST_RUN);
            i2cAccessEn      <= !hwSelMode && state != cgc_pkg::ST_STRAP;
            crystalCapHalfPf <= `CGC_CAP_BASE + {1'b0, crystalTuneCode};
            spreadActive     <= spreadEnable && spreadCode >= `CGC_SPREAD_MIN
                                && spreadCode <= `CGC_SPREAD_MAX;
            spreadDevQuarterPct <= spreadDownMode ? {spreadCode, 1'b0} : {1'b0, spreadCode};
        end
    end

    // ************************************
    // output gating
    // ************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            globalShutdown <= 1'b0;
        else
            globalShutdown <= pinFunctionBit && pinSync[0];
    end

    genvar gi;
    generate
        for (gi = 0; gi < `CGC_NUM_OUT; gi++)
        begin : g_out
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    outputMode[2*gi +: 2] <= cgc_pkg::MODE_TRI;
                else
                    outputMode[2*gi +: 2] <= gate_mode(pinFunctionBit, pinPolarityBit,
                        outputActiveBit[gi], outputEnableBit[gi], pinSync[0]);
            end
        end
    endgenerate

    // ************************************
    // link side
    // ************************************
    always_ff @(posedge linkClk)
    begin
        rstMeta <= rst;
        linkRst <= rstMeta;
        lnkMeta <= {deviceReady, i2cAccessEn, slaveAddrSelBit, ackTgl};
        lnkSync <= lnkMeta;
    end

    assign linkBusy  = reqTgl ^ lnkSync[0];
    assign ownAddr   = lnkSync[1] ? `CGC_ADDR_SEC : `CGC_ADDR_PRI;
    assign addrMatch = linkAddrByte[7:1] == ownAddr[7:1];
    assign linkAck   = !linkBusy && (linkAddrValid ?
                       (addrMatch && lnkSync[3] && lnkSync[2]) :
                       (linkDataValid && addressed));

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            addressed <= 1'b0;
            writeDir  <= 1'b0;
            byteCnt   <= 2'h0;
            cmdCode   <= 8'h00;
            cmdIsSave <= 1'b0;
            reqTgl    <= 1'b0;
        end
        else if (linkAddrValid)
        begin
            addressed <= linkAck;
            writeDir  <= !linkAddrByte[0];
            byteCnt   <= 2'h0;
        end
        else if (linkDataValid && addressed)
        begin
            if (byteCnt == 2'h0)
                cmdCode <= linkDataByte;
            if (byteCnt != 2'h3)
                byteCnt <= byteCnt + 2'h1;
        end
        else if (linkStop)
        begin
            addressed <= 1'b0;
            if (addressed && writeDir && byteCnt == 2'h1 && !linkBusy
                && (cmdCode == `CGC_CMD_SAVE || cmdCode == `CGC_CMD_RESTORE))
            begin
                cmdIsSave <= (cmdCode == `CGC_CMD_SAVE);
                reqTgl    <= !reqTgl;
            end
        end
    end

    // ************************************
    // checks
    // ************************************
    a_hw_select: assert property (@(posedge sys_clk) disable iff (rst)
        configLoadReq && selUsesPins |-> configLoadSel == $past(pinSel))
        else $error("pin mode loaded wrong configuration");
    a_link_cfg0: assert property (@(posedge sys_clk) disable iff (rst)
        configLoadReq && !hwSelMode |-> configLoadSel == 2'h0)
        else $error("link mode loaded nonzero configuration");
    a_early_pins: assert property (@(posedge sys_clk) disable iff (rst)
        state == cgc_pkg::ST_RUN && !porDone && !linkPend && !savePend && !restPend
        |=> state != cgc_pkg::ST_LOAD)
        else $error("reload before power-up window ended");
    a_settle_hold: assert property (@(posedge sys_clk) disable iff (rst)
        configLoadReq |=> !deviceReady [*8])
        else $error("ready during settle");
    a_spread_range: assert property (@(posedge sys_clk) disable iff (rst)
        spreadActive |-> spreadDevQuarterPct >= 5'h01 && spreadDevQuarterPct <= 5'h14)
        else $error("spread out of range");
    a_xtal_max: assert property (@(posedge sys_clk) disable iff (rst)
        crystalTuneCode == 6'h3f |=> crystalCapHalfPf == 7'h51)
        else $error("crystal capacitance wrong");
    a_save_start: assert property (@(posedge sys_clk) disable iff (rst)
        state == cgc_pkg::ST_RUN && savePend && !linkPend |=> otpSaveStart && !otpRestoreStart)
        else $error("save not started");
    a_restore_start: assert property (@(posedge sys_clk) disable iff (rst)
        state == cgc_pkg::ST_RUN && restPend && !savePend && !linkPend |=> otpRestoreStart)
        else $error("restore not started");
    a_powerup_restore: assert property (@(posedge sys_clk) disable iff (rst)
        state == cgc_pkg::ST_RESTORE && $past(state) == cgc_pkg::ST_STRAP |-> otpRestoreStart)
        else $error("no restore at power-up");
    a_global_shut: assert property (@(posedge sys_clk) disable iff (rst)
        pinFunctionBit && pinSync[0] |=> globalShutdown && outputMode[1:0] == cgc_pkg::MODE_SHUT)
        else $error("global shutdown not applied");
    a_tristate: assert property (@(posedge sys_clk) disable iff (rst)
        !pinFunctionBit && !outputActiveBit[0] |=> outputMode[1:0] == cgc_pkg::MODE_TRI)
        else $error("inactive output not tri-stated");
    a_ack_withheld: assert property (@(posedge linkClk) disable iff (linkRst)
        linkBusy |-> !linkAck)
        else $error("acknowledge during save or restore");

endmodule : cgc_config_ctrl

// ===== cgc_link_master.sv
/*
 * link master model: address byte, command bytes, stop
 * assumes: link clock stands high between frames, bench calls send
 */
`timescale 1ns/10ps
module cgc_link_master (
    output logic       linkClk,
    output logic       linkAddrValid,
    output logic [7:0] linkAddrByte,
    output logic       linkDataValid,
    output logic [7:0] linkDataByte,
    output logic       linkStop,
    input  wire logic  linkAck
);
    logic smp;
    logic ackAddr;

    initial {linkClk, linkAddrValid, linkAddrByte, linkDataValid, linkDataByte} = 19'h40000;
    initial linkStop = 1'b0;

    // one link cycle; answer sampled just before the rising edge
    task cyc;
        #16 linkClk = 1'b0;
        #15 smp = linkAck;
        #1 linkClk = 1'b1;
        #1;
    endtask : cyc

    // nd < 0 gives idle clocks only; a refused address ends the frame
    task send(input int nd, input logic [7:0] a, input logic [7:0] c);
        int i;
        repeat (4) cyc;
        if (nd >= 0)
        begin
            linkAddrValid = 1'b1;
            linkAddrByte  = a;
            cyc;
            ackAddr       = smp;
            linkAddrValid = 1'b0;
            linkAddrByte  = ~a;
            if (!smp) nd = 0;
            for (i = 0; i < nd; i++)
            begin
                linkDataValid = 1'b1;
                linkDataByte  = c;
                cyc;
                linkDataValid = 1'b0;
                linkDataByte  = ~c;
            end
            linkStop = 1'b1;
            cyc;
            linkStop = 1'b0;
        end
    endtask : send
endmodule : cgc_link_master

// ===== cgc_pkg.sv
/*
 * types of the clock generator configuration and output control block
 * assumes: compiled before the block
 */
package cgc_pkg;

    typedef enum logic [2:0] {
        ST_STRAP   = 3'b000,
        ST_RESTORE = 3'b001,
        ST_LOAD    = 3'b010,
        ST_SETTLE  = 3'b011,
        ST_RUN     = 3'b100,
        ST_OTP     = 3'b101
    } cgc_state_t;

    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'b00,
        MODE_TRI    = 2'b01,
        MODE_HILO   = 2'b10,
        MODE_SHUT   = 2'b11
    } cgc_mode_t;

endpackage : cgc_pkg

// ===== cgc_regs.svh
/*
 * constants of the clock generator configuration and output control block
 * assumes: included by its bare name, 25 MHz system clock
 */
`ifndef CGC_REGS_SVH
`define CGC_REGS_SVH

// ************************************
// timing
// ************************************
`define CGC_CLK_MHZ     25
`define CGC_POR_MS      10
`define CGC_SETTLE_US   1000
`define CGC_SYNC_WAIT   18'h00003

// ************************************
// link
// ************************************
`define CGC_ADDR_PRI    8'hd4
`define CGC_ADDR_SEC    8'hd0
`define CGC_CMD_SAVE    8'hb0
`define CGC_CMD_RESTORE 8'hb1

// ************************************
// fields
// ************************************
`define CGC_NUM_OUT     4
`define CGC_CAP_BASE    7'h12
`define CGC_SPREAD_MIN  4'h1
`define CGC_SPREAD_MAX  4'ha

`endif

// ===== test_cgc_config_ctrl.sv
/*
 * self-checking bench of the configuration and output control block
 * assumes: link master model beside it; memory engine modelled here
 */
`timescale 1ns/10ps
`include "cgc_regs.svh"
module test_cgc_config_ctrl;
    logic        sys_clk, rst, strapLatchPin, configChoiceLo, configChoiceHi, otpDone;
    logic        powerDownOrGatePin, i2cDefaultPickBit, slaveAddrSelBit, spreadActive;
    logic        otpSaveTrigger, otpRestoreTrigger, pinPolarityBit, pinFunctionBit;
    logic [3:0]  outputActiveBit, outputEnableBit, spreadCode;
    logic [5:0]  crystalTuneCode;
    logic        spreadEnable, spreadDownMode, linkClk, linkAddrValid, linkDataValid;
    logic [7:0]  linkAddrByte, linkDataByte, outputMode, nSave, nRest, nLoad, sv, rs, a, c;
    logic        linkStop, linkAck, configLoadReq, loadI2cDefaults, i2cAccessEn;
    logic        deviceReady, otpSaveStart, otpRestoreStart, globalShutdown;
    logic [1:0]  configLoadSel, m, nd;
    logic [6:0]  crystalCapHalfPf;
    logic [4:0]  spreadDevQuarterPct, dly;
    logic        ack, act, en, ea, ds, dr;
    logic [21:0] tbl [6];
    int          error_cnt, cmp_count, cycles, k;

    cgc_config_ctrl #(.POR_CYCLES(50), .SETTLE_CYCLES(20)) u_cgc_config_ctrl (
        .sys_clk, .rst, .strapLatchPin, .configChoiceLo, .configChoiceHi, .powerDownOrGatePin,
        .i2cDefaultPickBit, .slaveAddrSelBit, .otpSaveTrigger, .otpRestoreTrigger, .otpDone,
        .pinPolarityBit, .pinFunctionBit, .outputActiveBit, .outputEnableBit, .crystalTuneCode,
        .spreadEnable, .spreadDownMode, .spreadCode, .linkClk, .linkAddrValid, .linkAddrByte,
        .linkDataValid, .linkDataByte, .linkStop, .linkAck, .configLoadReq, .configLoadSel,
        .loadI2cDefaults, .i2cAccessEn, .deviceReady, .otpSaveStart, .otpRestoreStart,
        .globalShutdown, .outputMode, .crystalCapHalfPf, .spreadActive, .spreadDevQuarterPct);

    cgc_link_master u_cgc_link_master (.linkClk, .linkAddrValid, .linkAddrByte,
        .linkDataValid, .linkDataByte, .linkStop, .linkAck);

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial {nSave, nRest, nLoad, dly, otpDone} = '0;

    // memory engine: done pulse 20 cycles after a start, plus timeout
    always @(posedge sys_clk)
    begin
        otpDone <= #1 (dly == 5'd1);
        nSave   <= nSave + 8'(otpSaveStart === 1'b1);
        nRest   <= nRest + 8'(otpRestoreStart === 1'b1);
        nLoad   <= nLoad + 8'(configLoadReq === 1'b1);
        dly     <= (otpSaveStart === 1'b1 || otpRestoreStart === 1'b1) ? 5'd20
                   : dly - 5'(dly != 5'd0);
        cycles  <= cycles + 1;
        if (cycles == 4000)
        begin
            error_cnt++;
            report_and_stop;
        end
    end

    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic wt(ref logic s, input int n);
        int i;
        for (i = 0; i < n && s !== 1'b1; i++) step(1);
        chk(s, 1'b1);
    endtask : wt

    task lm(input int n, input logic [7:0] ad, input logic [7:0] cm);
        u_cgc_link_master.send(n, ad, cm);
        ack = u_cgc_link_master.ackAddr;
    endtask : lm

    task powerup;
        rst = 1'b1;
        u_cgc_link_master.send(-1, 8'h00, 8'h00);
        step(10);
        chk(outputMode, 8'h55);
        chk(crystalCapHalfPf, 7'h12);
        rst = 1'b0;
        wt(otpRestoreStart, 8);
        wt(configLoadReq, 40);
        wt(deviceReady, 40);
    endtask : powerup

    function automatic logic [1:0] mode_of(input logic f, p, o, e, s);
        if (f && s) return cgc_pkg::MODE_SHUT;
        if (!o) return cgc_pkg::MODE_TRI;
        if (!e) return cgc_pkg::MODE_ACTIVE;
        if (f) return p ? cgc_pkg::MODE_HILO : cgc_pkg::MODE_ACTIVE;
        return (s != p) ? cgc_pkg::MODE_HILO : cgc_pkg::MODE_ACTIVE;
    endfunction : mode_of

    task report_and_stop;
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        {strapLatchPin, configChoiceHi, configChoiceLo, i2cDefaultPickBit} = 4'b1100;
        {powerDownOrGatePin, slaveAddrSelBit, otpSaveTrigger, otpRestoreTrigger} = '0;
        {pinPolarityBit, pinFunctionBit, spreadEnable, spreadDownMode} = '0;
        {outputActiveBit, outputEnableBit, spreadCode, crystalTuneCode} = '0;
        tbl = '{{1'b0, 2'd1, `CGC_ADDR_PRI, `CGC_CMD_SAVE, 3'b110},
                {1'b0, 2'd1, `CGC_ADDR_SEC, `CGC_CMD_RESTORE, 3'b000},
                {1'b1, 2'd1, `CGC_ADDR_SEC, `CGC_CMD_RESTORE, 3'b101},
                {1'b1, 2'd2, `CGC_ADDR_SEC, `CGC_CMD_SAVE, 3'b100},
                {1'b1, 2'd1, 8'hd1, `CGC_CMD_SAVE, 3'b100},
                {1'b1, 2'd1, `CGC_ADDR_PRI, `CGC_CMD_SAVE, 3'b000}};
        powerup;
        chk(configLoadSel, 2'b10);
        chk(loadI2cDefaults, 1'b0);
        chk(i2cAccessEn, 1'b0);
        strapLatchPin = 1'b0;
        lm(1, `CGC_ADDR_PRI, `CGC_CMD_SAVE);
        chk(ack, 1'b0);
        for (k = 0; k < 64; k += 21)
        begin
            crystalTuneCode = 6'(k);
            step(2);
            chk(crystalCapHalfPf, 7'h12 + 7'(k));
        end
        for (k = 0; k < 16; k++)
        begin
            spreadCode = 4'(k[0]) + (k[1] ? 4'ha : 4'h0);
            {spreadEnable, spreadDownMode} = 2'(k >> 2);
            step(2);
            act = spreadEnable && spreadCode >= 4'h1 && spreadCode <= 4'ha;
            chk(spreadActive, act);
            if (act) chk(spreadDevQuarterPct, 5'(spreadCode) << spreadDownMode);
        end
        for (k = 0; k < 32; k++)
        begin
            {pinFunctionBit, pinPolarityBit, act, en, powerDownOrGatePin} = 5'(k);
            outputActiveBit = {4{act}};
            outputEnableBit = {4{en}};
            m = mode_of(pinFunctionBit, pinPolarityBit, act, en, powerDownOrGatePin);
            step(5);
            chk(outputMode, {4{m}});
            chk(globalShutdown, pinFunctionBit & powerDownOrGatePin);
        end
        powerDownOrGatePin = 1'b0;
        chk(i2cAccessEn, 1'b0);
        configChoiceLo = 1'b1;
        wt(configLoadReq, 8);
        chk(configLoadSel, 2'b11);
        step(1);
        wt(deviceReady, 40);
        configChoiceHi = 1'b0;
        wt(configLoadReq, 8);
        chk(configLoadSel, 2'b01);
        step(1);
        wt(deviceReady, 40);
        otpSaveTrigger = 1'b1;
        wt(otpSaveStart, 5);
        otpSaveTrigger = 1'b0;
        step(3);
        wt(deviceReady, 40);
        otpRestoreTrigger = 1'b1;
        wt(otpRestoreStart, 5);
        otpRestoreTrigger = 1'b0;
        step(3);
        wt(deviceReady, 40);
        i2cDefaultPickBit = 1'b1;
        powerup;
        chk(i2cAccessEn, 1'b1);
        chk(loadI2cDefaults, 1'b1);
        sv = nLoad;
        configChoiceHi = 1'b1;
        step(70);
        chk(nLoad, sv);
        rs = nRest;
        lm(1, `CGC_ADDR_PRI, `CGC_CMD_RESTORE);
        chk(ack, 1'b1);
        lm(0, `CGC_ADDR_PRI, 8'h00);
        chk(ack, 1'b0);
        step(60);
        chk(nRest, rs + 8'h01);
        for (k = 0; k < 6; k++)
        begin
            {slaveAddrSelBit, nd, a, c, ea, ds, dr} = tbl[k];
            sv = nSave;
            rs = nRest;
            lm(nd, a, c);
            chk(ack, ea);
            step(60);
            chk(nSave, sv + 8'(ds));
            chk(nRest, rs + 8'(dr));
        end
        report_and_stop;
    end
endmodule : test_cgc_config_ctrl
